// *** logic/eee_lpi_regs.vh ***
// constants for the low-power-idle control block
// assumes inclusion by bare name from the design file
`ifndef EEE_LPI_REGS_VH
`define EEE_LPI_REGS_VH
`define ELP_OFS_CSR 12'h030
`define ELP_OFS_TMR 12'h034
`define ELP_OFS_IRQ 12'h038
`define ELP_OFS_MASK 12'h03c
`define ELP_CSR_AUTO 19
`define ELP_CSR_QUAL 18
`define ELP_CSR_LINK 17
`define ELP_CSR_REQ 16
`define ELP_CSR_RXACT 9
`define ELP_CSR_TXACT 8
`define ELP_CSR_RXEX 3
`define ELP_CSR_RXEN 2
`define ELP_CSR_TXEX 1
`define ELP_CSR_TXEN 0
`define ELP_IRQ_BIT 10
`define ELP_HOLD_RESET 10'h3e8
`define ELP_WAKE_RESET 16'h0000
`define ELP_CLK_MHZ 100
`define ELP_US_NS 1000
`define ELP_CLK_NS 10
`define ELP_US_CYCLES (`ELP_US_NS / `ELP_CLK_NS)
`define ELP_MS_US 1000
`define ELP_US_LAST 7'h63
`define ELP_MS_LAST 10'h3e7
`endif

// *** logic/elp_ctrl.v ***
// low-power-idle control and status block with AHB-Lite register slave
// assumes one clock, a PHY rx lpi indication from another domain, tx busy from the MAC
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eee_lpi_regs.vh"
module elp_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire tx_frame_pending,
  input wire tx_busy,
  input wire tx_fifo_flush,
  input wire rx_lpi_detect,
  output reg tx_lpi_pattern,
  output reg tx_resume_ok,
  output reg lpi_irq
);
  localparam ST_NORM = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_LPI = 2'h2;
  localparam ST_WAKE = 2'h3;

  reg [1:0] state_reg;
  reg auto_reg, qual_reg, link_reg, req_reg;
  reg rxex_reg, rxen_reg, txex_reg, txen_reg;
  reg [9:0] hold_reg;
  reg [15:0] wake_reg;
  reg irq_reg, mask_reg;
  reg rx_s1_reg, rx_s2_reg, rx_prev_reg;
  reg [6:0] us_cnt_reg;
  reg [9:0] ms_cnt_reg;
  reg [10:0] link_ms_reg;
  reg [16:0] wake_us_reg;
  reg ph_wr_reg, ph_rd_reg;
  reg [11:0] ph_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // ahb address phase capture; zero wait states
  // hsize is ignored: every register is one aligned word
  wire take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr_reg <= take & hwrite;
      ph_rd_reg <= take & ~hwrite;
      if (take) begin
        ph_addr_reg <= haddr[11:0];
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  wire wr_csr = ph_wr_reg & (ph_addr_reg == `ELP_OFS_CSR);
  wire wr_tmr = ph_wr_reg & (ph_addr_reg == `ELP_OFS_TMR);
  wire wr_msk = ph_wr_reg & (ph_addr_reg == `ELP_OFS_MASK);
  // byte 0 read clears flags; a word read always covers byte 0
  wire rd_csr = take & ~hwrite & (haddr[11:0] == `ELP_OFS_CSR);

  ////////////////////////////////////////////////////////////////////////////
  // prescalers; ms tick derived from us tick
  // free-running phase: the first tick of any wait may come at once
  wire us_tick = (us_cnt_reg == `ELP_US_LAST);
  wire ms_tick = us_tick & (ms_cnt_reg == `ELP_MS_LAST);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_cnt_reg <= 7'h00;
      ms_cnt_reg <= 10'h000;
    end else begin
      us_cnt_reg <= us_tick ? 7'h00 : us_cnt_reg + 7'h01;
      if (us_tick) begin
        ms_cnt_reg <= ms_tick ? 10'h000 : ms_cnt_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rx lpi indication synchroniser
  // the phy side is asynchronous; only the second stage feeds logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_prev_reg <= 1'b0;
    end else begin
      rx_s1_reg <= rx_lpi_detect;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end
  wire rx_enter = rx_s2_reg & ~rx_prev_reg;
  wire rx_leave = ~rx_s2_reg & rx_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link-up hold counter, restarts whenever link drops
  // the first ms tick may come at once, so one extra tick is counted;
  // the hold is then never shorter than programmed
  wire hold_zero = (hold_reg == 10'h000);
  wire link_held = hold_zero | (link_ms_reg > {1'b0, hold_reg});
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_ms_reg <= 11'h000;
    end else if (!link_reg) begin
      link_ms_reg <= 11'h000;
    end else if (ms_tick && !link_held) begin
      link_ms_reg <= link_ms_reg + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit lpi state machine
  wire tx_idle = ~tx_busy & ~tx_frame_pending;
  wire auto_wake = auto_reg & (tx_frame_pending | tx_fifo_flush);
  // same extra tick for the wake wait, for the same reason
  wire wake_over = (wake_reg == 16'h0000) | (wake_us_reg > {1'b0, wake_reg});
  // software write of request within this cycle takes effect next cycle
  reg [1:0] state_next;
  reg tx_enter, tx_leave, wake_done;
  always @* begin
    state_next = state_reg;
    tx_enter = 1'b0;
    tx_leave = 1'b0;
    wake_done = 1'b0;
    case (state_reg)
      ST_NORM: begin
        if (req_reg) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!req_reg) begin
          state_next = ST_NORM;
        end else if (link_reg && link_held && (!auto_reg || tx_idle)) begin
          state_next = ST_LPI;
          tx_enter = 1'b1;
        end
      end
      ST_LPI: begin
        // link drop also ends lpi: the pattern is meaningless on a dead link
        if (!req_reg || auto_wake || !link_reg) begin
          state_next = ST_WAKE;
          tx_leave = 1'b1;
        end
      end
      ST_WAKE: begin
        if (wake_over) begin
          state_next = ST_NORM;
          wake_done = 1'b1;
        end
      end
      default: state_next = ST_NORM;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_NORM;
      wake_us_reg <= 17'h00000;
      tx_lpi_pattern <= 1'b0;
      tx_resume_ok <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_WAKE) begin
        wake_us_reg <= 17'h00000;
      end else if (us_tick && !wake_over) begin
        wake_us_reg <= wake_us_reg + 17'h00001;
      end
      tx_lpi_pattern <= (state_next == ST_LPI);
      tx_resume_ok <= (state_next == ST_NORM) || (state_next == ST_ARM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; hardware set wins over read clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_reg <= 1'b0;
      qual_reg <= 1'b0;
      link_reg <= 1'b0;
      req_reg <= 1'b0;
      rxex_reg <= 1'b0;
      rxen_reg <= 1'b0;
      txex_reg <= 1'b0;
      txen_reg <= 1'b0;
      hold_reg <= `ELP_HOLD_RESET;
      wake_reg <= `ELP_WAKE_RESET;
      irq_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (wr_csr) begin
        auto_reg <= hwdata[`ELP_CSR_AUTO];
        qual_reg <= hwdata[`ELP_CSR_QUAL];
        link_reg <= hwdata[`ELP_CSR_LINK];
      end
      if (auto_reg && tx_leave) begin
        req_reg <= 1'b0;
      end else if (wr_csr) begin
        req_reg <= hwdata[`ELP_CSR_REQ];
      end
      if (rx_leave) rxex_reg <= 1'b1;
      else if (rd_csr) rxex_reg <= 1'b0;
      if (rx_enter) rxen_reg <= 1'b1;
      else if (rd_csr) rxen_reg <= 1'b0;
      // a link-drop exit with the request still set is not a software exit
      if (wake_done && !req_reg) txex_reg <= 1'b1;
      else if (rd_csr) txex_reg <= 1'b0;
      if (tx_enter) txen_reg <= 1'b1;
      else if (rd_csr) txen_reg <= 1'b0;
      if (rx_enter | rx_leave | tx_enter | wake_done) irq_reg <= 1'b1;
      else if (rd_csr) irq_reg <= 1'b0;
      if (wr_tmr) begin
        hold_reg <= hwdata[25:16];
        wake_reg <= hwdata[15:0];
      end
      if (wr_msk) begin
        mask_reg <= hwdata[`ELP_IRQ_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered from the address phase
  // the read takes values from before any flag clear of the same edge
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    case (haddr[11:0])
      `ELP_OFS_CSR: begin
        rd_next[`ELP_CSR_AUTO] = auto_reg;
        rd_next[`ELP_CSR_QUAL] = qual_reg;
        rd_next[`ELP_CSR_LINK] = link_reg;
        rd_next[`ELP_CSR_REQ] = req_reg;
        rd_next[`ELP_CSR_RXACT] = rx_s2_reg;
        rd_next[`ELP_CSR_TXACT] = (state_reg == ST_LPI);
        rd_next[`ELP_CSR_RXEX] = rxex_reg;
        rd_next[`ELP_CSR_RXEN] = rxen_reg;
        rd_next[`ELP_CSR_TXEX] = txex_reg;
        rd_next[`ELP_CSR_TXEN] = txen_reg;
      end
      `ELP_OFS_TMR: rd_next = {6'h00, hold_reg, wake_reg};
      `ELP_OFS_IRQ: rd_next[`ELP_IRQ_BIT] = irq_reg;
      `ELP_OFS_MASK: rd_next[`ELP_IRQ_BIT] = mask_reg;
      default: rd_next = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      lpi_irq <= 1'b0;
    end else begin
      if (take && !hwrite) begin
        hrdata <= rd_next;
      end
      // a masked status still reads back; only the output is held low
      lpi_irq <= irq_reg & ~mask_reg;
    end
  end
endmodule
`default_nettype wire

// *** tb/elp_checker.sv ***
// port checker for the lpi control block
// assumes it is bound onto elp_ctrl
`timescale 1ns/1ps
`default_nettype none
module elp_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic tx_frame_pending,
  input wire logic tx_busy,
  input wire logic tx_fifo_flush,
  input wire logic rx_lpi_detect,
  input wire logic tx_lpi_pattern,
  input wire logic tx_resume_ok,
  input wire logic lpi_irq
);
  logic wr_reg, auto_reg, link_reg, req_reg, mask_reg;
  logic [11:0] wa_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow of mode bits; misses the hardware clear of the request in auto mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_reg, auto_reg, link_reg, req_reg, mask_reg} <= 5'h00;
      wa_reg <= 12'h000;
    end else begin
      wr_reg <= hsel && hready && htrans[1] && hwrite;
      wa_reg <= haddr[11:0];
      if (wr_reg && wa_reg == 12'h030) begin
        {auto_reg, link_reg, req_reg} <= {hwdata[19], hwdata[17:16]};
      end
      if (wr_reg && wa_reg == 12'h03c) begin
        mask_reg <= hwdata[10];
      end
    end
  end
  ////////////////////////////////////////
  sequence s_leave;
    ##[1:3] !tx_lpi_pattern;
  endsequence
  pat_resume_a: assert property (tx_lpi_pattern |-> !tx_resume_ok)
    else $error("resume allowed during lpi");
  resume_rise_a: assert property ($rose(tx_resume_ok) |-> !$past(tx_lpi_pattern))
    else $error("resume without wake gap");
  link_drop_a: assert property (!link_reg && !$past(link_reg, 3) |-> !tx_lpi_pattern)
    else $error("lpi sent with link down");
  auto_busy_a: assert property (auto_reg && $rose(tx_lpi_pattern)
    |-> $past(!tx_busy && !tx_frame_pending)) else $error("auto entry while busy");
  auto_wake_a: assert property (auto_reg && tx_lpi_pattern
    && (tx_frame_pending || tx_fifo_flush) |-> s_leave) else $error("auto wake missed");
  manual_hold_a: assert property (!auto_reg && req_reg && link_reg && tx_lpi_pattern
    |=> tx_lpi_pattern) else $error("manual lpi left");
  irq_mask_a: assert property (mask_reg && $past(mask_reg) |-> !lpi_irq)
    else $error("masked irq raised");
  irq_rx_a: assert property ($rose(rx_lpi_detect) && !mask_reg |-> ##[1:8] lpi_irq)
    else $error("rx entry gave no irq");
endmodule
bind elp_ctrl elp_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .tx_frame_pending(tx_frame_pending), .tx_busy(tx_busy), .tx_fifo_flush(tx_fifo_flush),
  .rx_lpi_detect(rx_lpi_detect), .tx_lpi_pattern(tx_lpi_pattern),
  .tx_resume_ok(tx_resume_ok), .lpi_irq(lpi_irq));
`default_nettype wire

// *** tb/elp_phy_model.sv ***
// phy stand-in raising its lpi indication toward the receiver
// assumes the bench asks for lpi on send_lpi
`timescale 1ns/1ps
`default_nettype none
module elp_phy_model (
  input wire logic hclk,
  input wire logic send_lpi,
  input wire logic [3:0] dly,
  output logic rx_lpi_detect
);
  logic [3:0] cnt_reg = 4'h0;
  logic det_reg = 1'b0;
  assign rx_lpi_detect = det_reg;
  ////////////////////////////////////////
  // a slow answer mimics a phy still settling its idle code
  always @(posedge hclk) begin
    if (det_reg == send_lpi) cnt_reg <= 4'h0;
    else if (cnt_reg >= dly) det_reg <= send_lpi;
    else cnt_reg <= cnt_reg + 4'h1;
  end
endmodule
`default_nettype wire

// *** tb/elp_ctrl_tb_top.sv ***
// self-checking bench for elp_ctrl
// assumes the checker and phy model compile first
`timescale 1ns/1ps
`default_nettype none
module elp_ctrl_tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pend = 0, busy = 0, flush = 0, send = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [1:0] htrans = 0;
  logic [3:0] dly = 0;
  logic [15:0] w;
  wire [31:0] hrdata;
  wire hrdy, hresp, rx_det, pat, res_ok, irq;
  int failures = 0, n_tests = 0, seed = 63, n;
  always #5 hclk = ~hclk;
  elp_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .tx_frame_pending(pend), .tx_busy(busy),
    .tx_fifo_flush(flush), .rx_lpi_detect(rx_det), .tx_lpi_pattern(pat),
    .tx_resume_ok(res_ok), .lpi_irq(irq));
  elp_phy_model PHY (.hclk(hclk), .send_lpi(send), .dly(dly), .rx_lpi_detect(rx_det));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    close_out;
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(12'h030, 32'h0, "csr reset");
    rc(12'h034, 32'h03e80000, "timer reset");
    rc(12'h040, 32'h0, "unmapped");
    w = 16'h0001 + 16'($unsigned($random(seed)) % 3);
    bus(1'b1, 12'h034, {16'h0000, w});
    rc(12'h034, {16'h0000, w}, "timers");
    busy <= 1'($random(seed));
    bus(1'b1, 12'h030, 32'h00030000);
    while (pat !== 1'b1) @(posedge hclk);
    pend <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("manual hold", {31'h0, pat}, 32'h1);
    rc(12'h038, 32'h400, "irq status");
    rc(12'h030, 32'h00030101, "entered");
    rc(12'h030, 32'h00030100, "flag clear");
    chk("irq clear", {31'h0, irq}, 32'h0);
    bus(1'b1, 12'h030, 32'h00020000);
    n = 0;
    while (res_ok !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    chk("wake", {31'h0, n >= 100 * w}, 32'h1);
    rc(12'h030, 32'h00020002, "exited");
    pend <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      busy <= 1'b1;
      bus(1'b1, 12'h030, 32'h000b0000);
      repeat (30) @(posedge hclk);
      chk("busy defer", {31'h0, pat}, 32'h0);
      busy <= 1'b0;
      while (pat !== 1'b1) @(posedge hclk);
      if (k == 0) pend <= 1'b1;
      else flush <= 1'b1;
      @(posedge hclk);
      flush <= 1'b0;
      while (res_ok !== 1'b1) @(posedge hclk);
      pend <= 1'b0;
      rc(12'h030, 32'h000a0003, "auto exit");
    end
    for (int m = 1; m >= 0; m--) begin
      bus(1'b1, 12'h03c, {21'h0, m[0], 10'h0});
      dly <= 4'($random(seed));
      send <= 1'b1;
      while (rx_det !== 1'b1) @(posedge hclk);
      repeat (6) @(posedge hclk);
      chk("irq mask", {31'h0, irq}, {31'h0, !m[0]});
      rc(12'h030, 32'h000a0204, "rx entry");
      send <= 1'b0;
      while (rx_det !== 1'b0) @(posedge hclk);
      repeat (6) @(posedge hclk);
      rc(12'h030, 32'h000a0008, "rx exit");
    end
    send <= 1'b1;
    while (rx_det !== 1'b1) @(posedge hclk);
    send <= 1'b0;
    while (rx_det !== 1'b0) @(posedge hclk);
    repeat (6) @(posedge hclk);
    rc(12'h030, 32'h000a000c, "rx both");
    bus(1'b1, 12'h030, 32'h00030000);
    while (pat !== 1'b1) @(posedge hclk);
    bus(1'b1, 12'h030, 32'h00010000);
    repeat (8) @(posedge hclk);
    chk("link drop", {31'h0, pat}, 32'h0);
    while (res_ok !== 1'b1) @(posedge hclk);
    rc(12'h030, 32'h00010001, "no exit flag");
    close_out;
  end
endmodule
`default_nettype wire
